// ===== logic/cbu_branch_unit.sv
`timescale 1ns/1ns
// Operation
// RULE_01 - Branch on negative jumps to pc plus offset plus one when N is 1.
// RULE_02 - Branch on positive jumps only when N is 0 and falls through else.
// RULE_03 - Signed greater-or-equal jumps when N xor V is 0.
// RULE_04 - Signed less-than jumps when N xor V is 1 and skips otherwise.
// RULE_05 - Half carry set jumps only when H is 1.
// RULE_06 - Half carry clear jumps only when H is 0.
// RULE_07 - Transfer bit set jumps only when T is 1.
// RULE_08 - Transfer bit clear jumps only when T is 0.
// RULE_09 - Overflow set jumps only when V is 1.
// RULE_10 - A taken branch loads old pc plus offset plus one.
// RULE_11 - Each branch finishes in one or two cycles by its outcome.
// RULE_12 - No branch ever alters any status flag.
// RULE_13 - Not taken costs one cycle, taken two; the offset is signed.
module cbu_branch_unit #(
  parameter int PC_W = cbu_pkg::PC_W,
  parameter int OFF_W = cbu_pkg::OFF_W
) (
  // Clock and reset
  input wire logic clk_i,
  input wire logic rst_i,
  // Branch request from decode
  input wire logic issue_i,
  input wire logic [3:0] op_i,
  input wire logic [OFF_W-1:0] offset_i,
  input wire logic [PC_W-1:0] pc_i,
  output logic ready_o,
  // Status register flags
  input wire logic [cbu_pkg::FLAG_W-1:0] flags_i,
  output logic flags_we_o,
  // Result to fetch logic
  output logic done_o,
  output logic taken_o,
  output logic [PC_W-1:0] pc_next_o,
  // Wishbone slave
  input wire logic wb_cyc_i,
  input wire logic wb_stb_i,
  input wire logic wb_we_i,
  input wire logic [7:0] wb_adr_i,
  input wire logic [3:0] wb_sel_i,
  input wire logic [31:0] wb_dat_i,
  output logic [31:0] wb_dat_o,
  output logic wb_ack_o
);

  // Sign extension needs a spare pc bit; the read port is only 32 bits
  if (OFF_W < 2 || OFF_W >= PC_W || PC_W > 32)
  begin : g_bad_width
    $error("offset width 2 or more and below pc width, pc width 32 at most");
  end

  cbu_pkg::cbu_state_t state;
  logic enable;
  logic last_taken;
  logic last_illegal;
  logic [cbu_pkg::CNT_W-1:0] taken_cnt;
  logic [PC_W-1:0] last_pc;
  logic [PC_W-1:0] target;
  logic [PC_W-1:0] offset_ext;
  logic [PC_W-1:0] next_seq;
  logic [PC_W-1:0] next_jump;
  logic cond;
  logic illegal;
  logic accept;
  logic wb_req;
  logic wb_wr;
  logic n_f;
  logic v_f;
  logic h_f;
  logic t_f;

  assign n_f = flags_i[cbu_pkg::FLAG_N];
  assign v_f = flags_i[cbu_pkg::FLAG_V];
  assign h_f = flags_i[cbu_pkg::FLAG_H];
  assign t_f = flags_i[cbu_pkg::FLAG_T];

  // Flags are only read here, never written back
  assign flags_we_o = 1'b0; // see RULE_12

  // Requests wait while busy or disabled by software
  assign ready_o = (state == cbu_pkg::CBU_IDLE) && enable;
  assign accept = issue_i && ready_o;

  // Offset is two's complement; wrap-around of pc is intended
  assign offset_ext = {{(PC_W-OFF_W){offset_i[OFF_W-1]}}, offset_i}; // see RULE_13
  assign next_seq = pc_i + {{(PC_W-1){1'b0}}, 1'b1};
  assign next_jump = next_seq + offset_ext; // see RULE_10

  // Condition test per branch select
  always_comb
  begin
    cond = 1'b0;
    illegal = 1'b0;
    case (op_i)
      cbu_pkg::branch_on_negative: cond = n_f; // see RULE_01
      cbu_pkg::branch_on_positive: cond = !n_f; // see RULE_02
      cbu_pkg::branch_signed_ge: cond = !(n_f ^ v_f); // see RULE_03
      cbu_pkg::branch_signed_lt: cond = n_f ^ v_f; // see RULE_04
      cbu_pkg::branch_half_carry_set: cond = h_f; // see RULE_05
      cbu_pkg::branch_half_carry_clear: cond = !h_f; // see RULE_06
      cbu_pkg::branch_transfer_bit_set: cond = t_f; // see RULE_07
      cbu_pkg::branch_transfer_bit_clear: cond = !t_f; // see RULE_08
      cbu_pkg::branch_overflow_set: cond = v_f; // see RULE_09
      // Unknown select falls through rather than jump anywhere
      default: illegal = 1'b1;
    endcase
  end

  // Sequencer: a taken branch spends one extra cycle
  always_ff @(posedge clk_i)
  begin
    if (rst_i)
    begin
      state <= cbu_pkg::CBU_IDLE;
    end
    else
    begin
      unique case (state)
        cbu_pkg::CBU_IDLE:
          if (accept && cond)
          begin
            state <= cbu_pkg::CBU_TAKEN; // see RULE_11
          end
        cbu_pkg::CBU_TAKEN:
          state <= cbu_pkg::CBU_IDLE;
      endcase
    end
  end

  // Jump target held over the second cycle
  always_ff @(posedge clk_i)
  begin
    if (rst_i)
    begin
      target <= '0;
    end
    else if (accept && cond)
    begin
      target <= next_jump; // see RULE_10
    end
  end

  // Result towards fetch, one-cycle done pulse
  always_ff @(posedge clk_i)
  begin
    if (rst_i)
    begin
      done_o <= 1'b0;
      taken_o <= 1'b0;
      pc_next_o <= '0;
    end
    else if (state == cbu_pkg::CBU_TAKEN)
    begin
      done_o <= 1'b1; // see RULE_13
      taken_o <= 1'b1;
      pc_next_o <= target;
    end
    else if (accept && !cond)
    begin
      done_o <= 1'b1; // see RULE_13
      taken_o <= 1'b0;
      pc_next_o <= next_seq;
    end
    else
    begin
      done_o <= 1'b0;
      taken_o <= 1'b0;
    end
  end

  // Software-visible history of the last branch
  always_ff @(posedge clk_i)
  begin
    if (rst_i)
    begin
      last_taken <= 1'b0;
      last_illegal <= 1'b0;
      last_pc <= '0;
    end
    else if (accept)
    begin
      last_taken <= cond;
      last_illegal <= illegal;
      last_pc <= cond ? next_jump : next_seq;
    end
  end

  // Wishbone: ack one cycle after request, write at the ack edge
  assign wb_req = wb_cyc_i && wb_stb_i;
  assign wb_wr = wb_req && wb_ack_o && wb_we_i;

  always_ff @(posedge clk_i)
  begin
    if (rst_i)
    begin
      wb_ack_o <= 1'b0;
    end
    else
    begin
      wb_ack_o <= wb_req && !wb_ack_o;
    end
  end

  // Control register; enable gates new requests
  always_ff @(posedge clk_i)
  begin
    if (rst_i)
    begin
      enable <= cbu_pkg::CTRL_EN_RST;
    end
    else if (wb_wr && wb_adr_i == cbu_pkg::REG_CTRL && wb_sel_i[0])
    begin
      enable <= wb_dat_i[cbu_pkg::CTRL_EN_BIT];
    end
  end

  // Taken counter; a count in the clearing cycle is kept
  always_ff @(posedge clk_i)
  begin
    if (rst_i)
    begin
      taken_cnt <= '0;
    end
    else if (wb_wr && wb_adr_i == cbu_pkg::REG_TAKEN_CNT)
    begin
      taken_cnt <= {{(cbu_pkg::CNT_W-1){1'b0}}, accept && cond};
    end
    else if (accept && cond)
    begin
      taken_cnt <= taken_cnt + {{(cbu_pkg::CNT_W-1){1'b0}}, 1'b1};
    end
  end

  // Read data captured with the ack, unmapped reads return zero
  always_ff @(posedge clk_i)
  begin
    if (rst_i)
    begin
      wb_dat_o <= 32'h0000_0000;
    end
    else if (wb_req && !wb_ack_o)
    begin
      wb_dat_o <= 32'h0000_0000;
      case (wb_adr_i)
        cbu_pkg::REG_CTRL:
          wb_dat_o[cbu_pkg::CTRL_EN_BIT] <= enable;
        cbu_pkg::REG_STATUS:
        begin
          wb_dat_o[cbu_pkg::STAT_BUSY_BIT] <= state != cbu_pkg::CBU_IDLE;
          wb_dat_o[cbu_pkg::STAT_TAKEN_BIT] <= last_taken;
          wb_dat_o[cbu_pkg::STAT_ILLEGAL_BIT] <= last_illegal;
        end
        cbu_pkg::REG_TAKEN_CNT:
          wb_dat_o[cbu_pkg::CNT_W-1:0] <= taken_cnt;
        cbu_pkg::REG_LAST_PC:
          wb_dat_o[PC_W-1:0] <= last_pc;
        default:
          wb_dat_o <= 32'h0000_0000;
      endcase
    end
  end

  default clocking cb @(posedge clk_i);
  endclocking
  default disable iff (rst_i);

  a_neg_taken: assert property ( // see RULE_01
    accept && op_i == cbu_pkg::branch_on_negative && n_f
    |=> !done_o ##1 (done_o && taken_o))
    else $error("negative branch not taken with N set");

  a_pos_skip: assert property ( // see RULE_02
    accept && op_i == cbu_pkg::branch_on_positive && n_f
    |=> done_o && !taken_o && pc_next_o == $past(pc_i) + 1'b1)
    else $error("positive branch did not fall through with N set");

  a_ge_taken: assert property ( // see RULE_03
    accept && op_i == cbu_pkg::branch_signed_ge && !(n_f ^ v_f)
    |-> ##2 (done_o && taken_o))
    else $error("signed ge branch missed with N xor V zero");

  a_lt_skip: assert property ( // see RULE_04
    accept && op_i == cbu_pkg::branch_signed_lt && !(n_f ^ v_f)
    |-> ##1 (done_o && !taken_o))
    else $error("signed lt branch taken with N xor V zero");

  a_flag_tests: assert property ( // see RULE_05
    accept && op_i inside {cbu_pkg::branch_half_carry_set,
      cbu_pkg::branch_half_carry_clear, cbu_pkg::branch_transfer_bit_set,
      cbu_pkg::branch_transfer_bit_clear, cbu_pkg::branch_overflow_set}
    |=> done_o == !(
      ($past(op_i) == cbu_pkg::branch_half_carry_set && $past(h_f)) ||
      ($past(op_i) == cbu_pkg::branch_half_carry_clear && !$past(h_f)) ||
      ($past(op_i) == cbu_pkg::branch_transfer_bit_set && $past(t_f)) ||
      ($past(op_i) == cbu_pkg::branch_transfer_bit_clear && !$past(t_f)) ||
      ($past(op_i) == cbu_pkg::branch_overflow_set && $past(v_f))))
    else $error("single flag branch outcome wrong");

  a_jump_target: assert property ( // see RULE_10
    done_o && taken_o |-> pc_next_o == PC_W'($past(pc_i, 2)
      + {{(PC_W-OFF_W){$past(offset_i[OFF_W-1], 2)}}, $past(offset_i, 2)}
      + 1'b1))
    else $error("taken branch target is not pc plus offset plus one");

  a_cycle_bound: assert property ( // see RULE_11
    accept |-> ##[1:2] done_o)
    else $error("branch did not finish in one or two cycles");

  a_flags_kept: assert property ( // see RULE_12
    issue_i || done_o |-> !flags_we_o)
    else $error("branch attempted to write status flags");

endmodule

// ===== logic/cbu_pkg.sv
package cbu_pkg;

  // Default widths of program counter and branch offset
  localparam int PC_W = 16;
  localparam int OFF_W = 7;

  // Status flag bit positions in the flag vector
  localparam int FLAG_N = 2;
  localparam int FLAG_V = 3;
  localparam int FLAG_H = 5;
  localparam int FLAG_T = 6;
  localparam int FLAG_W = 8;

  // Cycles spent per outcome
  localparam int NOT_TAKEN_CYC = 1;
  localparam int TAKEN_CYC = 2;

  // Register map, byte addresses
  localparam logic [7:0] REG_CTRL = 8'h00;
  localparam logic [7:0] REG_STATUS = 8'h04;
  localparam logic [7:0] REG_TAKEN_CNT = 8'h08;
  localparam logic [7:0] REG_LAST_PC = 8'h0c;

  // Field positions and reset values
  localparam int CTRL_EN_BIT = 0;
  localparam logic CTRL_EN_RST = 1'b1;
  localparam int STAT_BUSY_BIT = 0;
  localparam int STAT_TAKEN_BIT = 1;
  localparam int STAT_ILLEGAL_BIT = 2;
  localparam int CNT_W = 16;

  // Branch selects
  typedef enum logic [3:0] {
    branch_on_negative = 4'h0,
    branch_on_positive = 4'h1,
    branch_signed_ge = 4'h2,
    branch_signed_lt = 4'h3,
    branch_half_carry_set = 4'h4,
    branch_half_carry_clear = 4'h5,
    branch_transfer_bit_set = 4'h6,
    branch_transfer_bit_clear = 4'h7,
    branch_overflow_set = 4'h8
  } cbu_op_t;

  // Sequencer states
  typedef enum logic [1:0] {
    CBU_IDLE = 2'b00,
    CBU_TAKEN = 2'b01
  } cbu_state_t;

endpackage

// ===== tb/cbu_flag_model.sv
`timescale 1ns/1ns
// Status flag register beside the core; only the bench or the unit loads it
module cbu_flag_model (
  // Clock and reset
  input wire logic clk_i,
  input wire logic rst_i,
  // Load from the bench and write from the unit
  input wire logic load_i,
  input wire logic [7:0] val_i,
  input wire logic we_i,
  // Flags to the unit
  output logic [7:0] flags_o
);
  // A stray write inverts every flag, so it cannot hide
  always_ff @(posedge clk_i)
  begin
    if (rst_i)
      flags_o <= 8'h00;
    else if (we_i)
      flags_o <= ~flags_o;
    else if (load_i)
      flags_o <= val_i;
  end
endmodule

// ===== tb/tb_conditional_branch_unit.sv
`timescale 1ns/1ns
`define CHK(a, b) begin n_compared++; if ((a) !== (b)) begin \
  $display("BAD %0t %h %h", $time, a, b); num_errors++; end end
module tb_conditional_branch_unit;
  logic clk_i = 0, rst_i = 1, issue = 0, ld = 0, we = 0, cyc = 0, stb = 0;
  logic [3:0] op = 4'h0;
  logic [6:0] off = 7'h00;
  logic [15:0] pc = 16'h0000;
  logic [7:0] fv = 8'h00, adr = 8'h00, flags;
  logic [31:0] dat = 32'h0000_0000, q;
  logic ready_o, flags_we_o, done_o, taken_o, wb_ack_o;
  logic [15:0] pc_next_o, exp_pc;
  logic [31:0] wb_dat_o;
  int num_errors = 0, n_compared = 0, seed = 62, n_taken = 0;
  // Free running core clock
  initial
  begin
    forever #5 clk_i = ~clk_i;
  end
  cbu_flag_model cbu_flag_model_inst (.clk_i(clk_i), .rst_i(rst_i),
    .load_i(ld), .val_i(fv), .we_i(flags_we_o), .flags_o(flags));
  cbu_branch_unit cbu_branch_unit_inst (.clk_i(clk_i), .rst_i(rst_i),
    .issue_i(issue), .op_i(op), .offset_i(off), .pc_i(pc),
    .ready_o(ready_o), .flags_i(flags), .flags_we_o(flags_we_o),
    .done_o(done_o), .taken_o(taken_o), .pc_next_o(pc_next_o),
    .wb_cyc_i(cyc), .wb_stb_i(stb), .wb_we_i(we), .wb_adr_i(adr),
    .wb_sel_i(4'hf), .wb_dat_i(dat), .wb_dat_o(wb_dat_o),
    .wb_ack_o(wb_ack_o));
  // Reference outcome from the flag tests alone
  function automatic logic exp_taken(input logic [3:0] o, input logic [7:0] f);
    logic n, v;
    n = f[cbu_pkg::FLAG_N];
    v = f[cbu_pkg::FLAG_V];
    case (o)
      4'h0: return n;
      4'h1: return !n;
      4'h2: return !(n ^ v);
      4'h3: return n ^ v;
      4'h4: return f[cbu_pkg::FLAG_H];
      4'h5: return !f[cbu_pkg::FLAG_H];
      4'h6: return f[cbu_pkg::FLAG_T];
      4'h7: return !f[cbu_pkg::FLAG_T];
      4'h8: return v;
      default: return 1'b0;
    endcase
  endfunction
  // Verdict and end of run
  task automatic complete_run();
    if (num_errors == 0 && n_compared > 0)
      $display("Finished cleanly");
    else
      $display("Finished with errors");
    $finish;
  endtask
  // One classic Wishbone cycle, held until ack
  task automatic wb(input logic w, input logic [7:0] a, input logic [31:0] d,
    output logic [31:0] r);
    int n;
    n = 0;
    @(posedge clk_i);
    cyc <= 1; stb <= 1; we <= w; adr <= a; dat <= d;
    do
    begin
      @(posedge clk_i);
      n++;
    end while (wb_ack_o !== 1'b1 && n < 20);
    r = wb_dat_o;
    cyc <= 0; stb <= 0; we <= 0;
    if (n >= 20)
    begin
      num_errors++;
      complete_run();
    end
  endtask
  // Load flags, issue one branch, check outcome, cycles and flags
  task automatic br(input logic [3:0] o, input logic [6:0] k,
    input logic [15:0] p, input logic [7:0] f);
    int n;
    logic t;
    t = exp_taken(o, f);
    exp_pc = p + {{9{k[6]}}, k} + 16'h0001;
    if (!t)
      exp_pc = p + 16'h0001;
    @(posedge clk_i);
    ld <= 1; fv <= f;
    @(posedge clk_i);
    ld <= 0; issue <= 1; op <= o; off <= k; pc <= p;
    n = 0;
    do
    begin
      @(posedge clk_i);
      n++;
    end while (ready_o !== 1'b1 && n < 20);
    issue <= 0;
    n = 0;
    do
    begin
      @(posedge clk_i);
      n++;
    end while (done_o !== 1'b1 && n < 20);
    if (n >= 20)
    begin
      num_errors++;
      complete_run();
    end
    n_taken += t;
    `CHK(taken_o, t)
    `CHK(n, t ? 2 : 1)
    `CHK(pc_next_o, exp_pc)
    `CHK(flags, f)
    `CHK(flags_we_o, 1'b0)
  endtask
  // Main sequence
  initial
  begin
    repeat (2) @(posedge clk_i);
    rst_i <= 0;
    @(posedge clk_i);
    `CHK(pc_next_o, 16'h0000)
    wb(1, cbu_pkg::REG_TAKEN_CNT, 32'h0000_0000, q);
    // Every select with all flags clear and then all set, then boundaries
    for (int i = 0; i < 9; i++)
    begin
      br(i[3:0], 7'h3f, 16'h1000, 8'h00);
      br(i[3:0], 7'h40, 16'h0000, 8'hff);
    end
    br(4'h3, 7'h01, 16'hffff, 8'h04);
    repeat (60)
      br($unsigned($random(seed)) % 9, $random(seed), $random(seed),
        $random(seed));
    wb(0, cbu_pkg::REG_TAKEN_CNT, 32'h0000_0000, q);
    `CHK(q[15:0], n_taken[15:0])
    wb(0, cbu_pkg::REG_LAST_PC, 32'h0000_0000, q);
    `CHK(q[15:0], exp_pc)
    // Illegal select falls through and is flagged
    br(4'h9, 7'h10, 16'h2000, 8'h00);
    wb(0, cbu_pkg::REG_STATUS, 32'h0000_0000, q);
    `CHK(q[cbu_pkg::STAT_ILLEGAL_BIT], 1'b1)
    `CHK(q[cbu_pkg::STAT_TAKEN_BIT], 1'b0)
    `CHK(q[cbu_pkg::STAT_BUSY_BIT], 1'b0)
    wb(0, 8'h10, 32'h0000_0000, q);
    `CHK(q, 32'h0000_0000)
    // Disabled unit refuses a request
    wb(1, cbu_pkg::REG_CTRL, 32'h0000_0000, q);
    @(posedge clk_i);
    issue <= 1;
    repeat (3) @(posedge clk_i);
    `CHK(ready_o, 1'b0)
    `CHK(done_o, 1'b0)
    issue <= 0;
    wb(1, cbu_pkg::REG_CTRL, 32'h0000_0001, q);
    wb(0, cbu_pkg::REG_CTRL, 32'h0000_0000, q);
    `CHK(q, 32'h0000_0001)
    br(4'h6, 7'h05, 16'h0100, 8'h40);
    complete_run();
  end
endmodule
